// ---- pkg/shs_pkg.sv ----
// package for the sampled hall threshold switch: thresholds, timing, states
// assumes a 25 MHz clock and a signed flux sample in units of 0.1 mT
package shs_pkg;
  localparam int SAMPLE_W = 12; // signed flux, 0.1 mT per lsb

  // thresholds in 0.1 mT, unipolar low-threshold typicals
  localparam logic signed [11:0] OPERATE_THRESHOLD = 12'sh019; // 2.5 mT
  localparam logic signed [11:0] RELEASE_THRESHOLD = 12'sh012; // 1.8 mT
  localparam logic signed [11:0] MIN_HYSTERESIS    = 12'sh001; // 0.1 mT

  localparam int CLOCK_HZ     = 25000000;
  localparam int RATE_FAST_HZ = 20;
  localparam int RATE_SLOW_HZ = 5;
  localparam int PERIOD_FAST  = CLOCK_HZ / RATE_FAST_HZ;
  localparam int PERIOD_SLOW  = CLOCK_HZ / RATE_SLOW_HZ;
  localparam int TON_US       = 100; // power-up settle time
  localparam int TON_CYCLES   = (TON_US * (CLOCK_HZ / 1000000));
  localparam int CNT_W        = 23;

  typedef enum logic [3:0] {
    SHS_POWERUP = 4'h1,
    SHS_SAMPLE  = 4'h2,
    SHS_DECIDE  = 4'h4,
    SHS_SLEEP   = 4'h8
  } shs_state_e;
endpackage

// ---- sim/shs_host_gpio.sv ----
// host controller input model: resolves one switch output pin and reads it
// assumes level and enable come straight from the switch, pull-up is a strap
module shs_host_gpio (
  input  wire logic clock,   // host sampling clock
  input  wire logic level,   // pin level from the switch
  input  wire logic oe,      // pin drive enable from the switch
  input  wire logic pullUp,  // board pull-up fitted
  output logic      pinRead  // value the host reads
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastDriven;

  // ==========================================
  // pin resolution
  // a floating pin without pull-up reads the opposite of its last level,
  // so a push-pull output that lets go cannot pass by luck
  always_comb pinRead = oe ? level : (pullUp ? 1'b1 : ~lastDriven);

  always_ff @(posedge clock) begin
    if (oe) lastDriven <= level;
  end
endmodule

// ---- sim/shs_switch_bench.sv ----
// self-checking bench for the hall threshold switch, one sample per reset
// assumes package periods are long, so only the first sample is reached
module shs_switch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import shs_pkg::*;

  logic                       clock = 1'b0;
  logic                       rst_n = 1'b0;
  logic signed [SAMPLE_W-1:0] flux = '0;
  logic                       unipolar = 1'b0;
  logic                       openDrain = 1'b0;
  logic                       slowRate = 1'b0;
  logic                       northLevel, northOe, southLevel, southOe, sampleStrobe;
  logic                       northPin, southPin;
  int                         nMismatch = 0;
  int                         samplesChecked = 0;
  int                         cycles = 0;
  logic signed [SAMPLE_W-1:0] corner [8] = '{12'sh019, 12'sh018, 12'shfe7, 12'shfe8,
                                             12'sh000, 12'sh800, 12'sh7ff, 12'sh012};

  shs_switch i_dut (.clock(clock), .rst_n(rst_n), .flux(flux), .unipolar(unipolar),
    .openDrain(openDrain), .slowRate(slowRate), .north_output(northLevel), .northOe(northOe),
    .south_output(southLevel), .southOe(southOe), .sampleStrobe(sampleStrobe));
  shs_host_gpio iNorthHost (.clock(clock), .level(northLevel), .oe(northOe),
    .pullUp(openDrain), .pinRead(northPin));
  shs_host_gpio iSouthHost (.clock(clock), .level(southLevel), .oe(southOe),
    .pullUp(openDrain), .pinRead(southPin));

  // ==========================================
  // clock and watchdog
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      nMismatch++;
      stopTest();
    end
  end

  // ==========================================
  // expectation and compare
  // first sample after reset: latch starts released, so operate level decides
  function automatic logic expActive(input logic signed [SAMPLE_W-1:0] f, input logic uni,
                                     input logic south);
    logic signed [SAMPLE_W:0] m;
    m = f;
    if (!uni) m = (f < 0) ? -m : m;
    else if (south) m = (f > 0) ? m : '0;
    else m = (f < 0) ? -m : '0;
    return m >= OPERATE_THRESHOLD;
  endfunction

  task automatic checkBit(input logic got, input logic want, input string what);
    samplesChecked++;
    if (got !== want) begin
      nMismatch++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, want);
    end
  endtask

  task automatic stopTest();
    $display("checked %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================
  // one reset, one sample, then a changing field that must be ignored
  task automatic runOne(input logic signed [SAMPLE_W-1:0] f, input logic [2:0] mode);
    logic an, as;
    int   k, extra;
    @(negedge clock);
    rst_n = 1'b0;
    flux = f;
    {unipolar, openDrain, slowRate} = mode;
    repeat (4) @(negedge clock);
    checkBit(northOe | southOe, 1'b0, "enable during reset");
    rst_n = 1'b1;
    k = 0;
    while (sampleStrobe !== 1'b1 && k < TON_CYCLES) begin
      @(negedge clock);
      k++;
    end
    checkBit(k < TON_CYCLES, 1'b1, "no sample within settle time");
    @(negedge clock);
    checkBit(sampleStrobe, 1'b0, "wake marker too long");
    repeat (3) @(negedge clock);
    an = expActive(f, mode[2], 1'b0);
    as = expActive(f, mode[2], 1'b1);
    for (int r = 0; r < 2; r++) begin
      checkBit(northPin, ~an, "north level");
      checkBit(northOe, mode[1] ? an : 1'b1, "north enable");
      checkBit(mode[2] ? southPin : southOe, mode[2] ? ~as : 1'b0, "south level");
      checkBit(mode[2] ? southOe : 1'b0, (mode[2] & ~mode[1]) | (mode[2] & as), "south enable");
      if (r == 0) begin
        extra = 0;
        flux = SAMPLE_W'($urandom);
        repeat (40) begin
          @(negedge clock);
          if (sampleStrobe === 1'b1) extra++;
        end
        checkBit(extra == 0, 1'b1, "early wake");
      end
    end
  endtask

  // ==========================================
  // main sequence: corner fields in every variant, then random ones
  initial begin
    void'($urandom(32'h632d));
    repeat (12) @(negedge clock);
    for (int i = 0; i < 8; i++)
      for (int m = 0; m < 8; m++)
        runOne(corner[i], 3'(m));
    for (int i = 0; i < 32; i++) runOne(SAMPLE_W'($urandom), 3'($urandom));
    stopTest();
  end
endmodule

// ---- src/shs_latch.sv ----
// one output's hysteresis decision latch
// assumes a magnitude already selected for this output's polarity
module shs_latch
  import shs_pkg::*;
(
  input  wire logic                      clock,    // oscillator clock
  input  wire logic                      rst_n,    // power-up reset
  input  wire logic                      evaluate, // one-cycle decide strobe
  input  wire logic signed [SAMPLE_W-1:0] level,    // polarity-matched flux
  output logic                           active    // field present
);
  logic next_active;

  always_comb begin
    next_active = active;
    if (evaluate) begin
      if (level >= OPERATE_THRESHOLD)
        next_active = 1'b1;
      else if (level < RELEASE_THRESHOLD)
        next_active = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      active <= 1'b0;
    else
      active <= next_active;
  end

  a_latch_hold: assert property (@(posedge clock) disable iff (!rst_n)
    !$past(evaluate) |-> active == $past(active))
    else $error("latch changed outside a decide strobe");
  a_latch_band: assert property (@(posedge clock) disable iff (!rst_n)
    evaluate && level < OPERATE_THRESHOLD && level >= RELEASE_THRESHOLD |=> $stable(active))
    else $error("latch moved inside hysteresis band");
endmodule

// ---- src/shs_switch.sv ----
// sampled hall threshold switch: wake, sample, decide, sleep
// assumes flux arrives asynchronously from the front end and is sampled on wake
module shs_switch
  import shs_pkg::*;
(
  input  wire logic                      clock,        // 25 MHz oscillator
  input  wire logic                      rst_n,        // power-up reset, active low
  input  wire logic signed [SAMPLE_W-1:0] flux,         // signed flux sample, async
  input  wire logic                      unipolar,     // strap: 1 unipolar, 0 omnipolar
  input  wire logic                      openDrain,    // strap: 1 open-drain outputs
  input  wire logic                      slowRate,     // strap: 1 selects 5 Hz
  output logic                           north_output, // north / omnipolar output level
  output logic                           northOe,      // north pin drive enable
  output logic                           south_output, // south output level
  output logic                           southOe,      // south pin drive enable
  output logic                           sampleStrobe  // one-cycle wake marker
);
  // ==========================================================
  // input synchronisers
  logic signed [SAMPLE_W-1:0] fluxMeta, fluxSync;
  logic [2:0]                 strapMeta, strapSync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fluxMeta  <= '0;
      fluxSync  <= '0;
      strapMeta <= 3'h0;
      strapSync <= 3'h0;
    end else begin
      fluxMeta  <= flux;
      fluxSync  <= fluxMeta;
      strapMeta <= {slowRate, openDrain, unipolar};
      strapSync <= strapMeta;
    end
  end

  // ==========================================================
  // straps caught once after release, so a mode never shifts mid-life
  logic [2:0] mode, next_mode;
  logic       modeTaken, next_modeTaken;
  logic [1:0] strapAge, next_strapAge;

  always_comb begin
    next_mode      = mode;
    next_modeTaken = modeTaken;
    next_strapAge  = strapAge;
    if (!modeTaken) begin
      if (strapAge == 2'h2) begin
        next_mode      = strapSync;
        next_modeTaken = 1'b1;
      end else
        next_strapAge = strapAge + 2'h1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= 3'h0;
      modeTaken <= 1'b0;
      strapAge  <= 2'h0;
    end else begin
      mode      <= next_mode;
      modeTaken <= next_modeTaken;
      strapAge  <= next_strapAge;
    end
  end

  wire isUni  = mode[0];
  wire isOd   = mode[1];
  wire isSlow = mode[2];

  // ==========================================================
  // sequencer
  shs_state_e             state, next_state;
  logic [CNT_W-1:0]       count, next_count;
  logic signed [SAMPLE_W-1:0] sample, next_sample;

  // first sample a few cycles after the straps are caught, far inside the settle time
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(4);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(PERIOD_FAST - 3);
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(PERIOD_SLOW - 3);

  always_comb begin
    next_state  = state;
    next_count  = count;
    next_sample = sample;
    case (state)
      SHS_POWERUP: begin
        // settle, then first sample well inside the power-up window
        if (modeTaken && count >= SETTLE_LAST)
          next_state = SHS_SAMPLE;
        else
          next_count = count + 23'h000001;
      end
      SHS_SAMPLE: begin
        next_sample = fluxSync;
        next_state  = SHS_DECIDE;
      end
      SHS_DECIDE: begin
        next_count = '0;
        next_state = SHS_SLEEP;
      end
      SHS_SLEEP: begin
        // wake period chosen by rate strap
        if (count == (isSlow ? SLOW_LAST : FAST_LAST)) begin
          next_count = '0;
          next_state = SHS_SAMPLE;
        end else
          next_count = count + 23'h000001;
      end
      default: begin
        next_state = SHS_POWERUP;
        next_count = '0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state  <= SHS_POWERUP;
      count  <= '0;
      sample <= '0;
    end else begin
      state  <= next_state;
      count  <= next_count;
      sample <= next_sample;
    end
  end

  wire evaluate = (state == SHS_DECIDE);
  assign sampleStrobe = (state == SHS_SAMPLE);

  // ==========================================================
  // polarity selection: positive is south near the top
  function automatic logic signed [SAMPLE_W-1:0] magOf(input logic signed [SAMPLE_W-1:0] v);
    // most negative code has no positive twin, so it saturates to full scale
    if (v == {1'b1, {(SAMPLE_W-1){1'b0}}})
      magOf = {1'b0, {(SAMPLE_W-1){1'b1}}};
    else
      magOf = v[SAMPLE_W-1] ? -v : v;
  endfunction

  logic signed [SAMPLE_W-1:0] northLevel, southLevel;

  always_comb begin
    if (isUni) begin
      northLevel = sample[SAMPLE_W-1] ? magOf(sample) : '0;
      southLevel = sample[SAMPLE_W-1] ? '0 : sample;
    end else begin
      northLevel = magOf(sample);
      southLevel = '0;
    end
  end

  logic northActive, southActive;

  // separate latch per output, both with the same package band
  shs_latch northLatch (
    .clock    (clock),
    .rst_n    (rst_n),
    .evaluate (evaluate),
    .level    (northLevel),
    .active   (northActive)
  );

  shs_latch southLatch (
    .clock    (clock),
    .rst_n    (rst_n),
    .evaluate (evaluate),
    .level    (southLevel),
    .active   (southActive)
  );

  // ==========================================================
  // pin drivers: field present pulls low, idle rests high
  logic next_north, next_northOe, next_south, next_southOe;

  always_comb begin
    next_north   = ~northActive;
    next_south   = ~southActive;
    // released until the straps are known, so an open-drain part never drives high
    next_northOe = modeTaken;
    next_southOe = isUni & modeTaken;
    if (isOd) begin
      // released when high so the pull-up sets the level
      next_north   = 1'b0;
      next_northOe = northActive;
      next_south   = 1'b0;
      next_southOe = southActive & isUni;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      north_output <= 1'b1;
      northOe      <= 1'b0;
      south_output <= 1'b1;
      southOe      <= 1'b0;
    end else begin
      north_output <= next_north;
      northOe      <= next_northOe;
      south_output <= next_south;
      southOe      <= next_southOe;
    end
  end

  // ==========================================================
  // checks
  sequence s_wake;
    state == SHS_SAMPLE;
  endsequence
  sequence s_decide;
    ##1 state == SHS_DECIDE ##1 state == SHS_SLEEP;
  endsequence

  a_wake_decide_sleep: assert property (@(posedge clock) disable iff (!rst_n)
    s_wake |-> s_decide)
    else $error("wake did not decide then sleep");
  a_first_sample: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(modeTaken) |-> ##[1:8] state == SHS_SAMPLE)
    else $error("first sample late after power-up");
  a_pushpull_driven: assert property (@(posedge clock) disable iff (!rst_n)
    modeTaken && !isOd && $past(modeTaken) |=> northOe)
    else $error("push-pull north output not driven");
  a_od_no_high: assert property (@(posedge clock) disable iff (!rst_n)
    modeTaken && isOd && $past(modeTaken) && $past(isOd) |-> !(northOe && north_output))
    else $error("open-drain drove high");
  a_uni_north_pos: assert property (@(posedge clock) disable iff (!rst_n)
    evaluate && isUni && !sample[SAMPLE_W-1] |-> northLevel == 0)
    else $error("north reacted to positive flux");
  a_uni_south_neg: assert property (@(posedge clock) disable iff (!rst_n)
    evaluate && isUni && sample[SAMPLE_W-1] |-> southLevel == 0)
    else $error("south reacted to negative flux");
  a_omni_operate: assert property (@(posedge clock) disable iff (!rst_n)
    evaluate && !isUni && magOf(sample) >= OPERATE_THRESHOLD |=> ##1 (isOd ? northOe : !north_output))
    else $error("omnipolar output missed operate");
  a_release_high: assert property (@(posedge clock) disable iff (!rst_n)
    evaluate && !isOd && northLevel < RELEASE_THRESHOLD |=> ##1 north_output)
    else $error("north did not release below release threshold");
  a_sleep_stable: assert property (@(posedge clock) disable iff (!rst_n)
    state == SHS_SLEEP && $past(state) == SHS_SLEEP && $past(state, 2) == SHS_SLEEP
      |-> $stable(north_output) && $stable(south_output))
    else $error("output moved during sleep");
endmodule
